// File: hdl/uht_pkg.sv
// Purpose: Shared constants for the USB host transaction control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register indices are kept as printed; byte address is four times the index
package uht_pkg;

	localparam int ADDR_W = 18;

	// Register indices and byte addresses
	localparam int IDX_CTRL = 32'h0000_C080;
	localparam int IDX_BUFP = 32'h0000_C082;
	localparam int IDX_CNT = 32'h0000_C084;
	localparam int IDX_RES = 32'h0000_C086;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'(IDX_CTRL * 4);
	localparam logic [ADDR_W-1:0] ADDR_BUFP = ADDR_W'(IDX_BUFP * 4);
	localparam logic [ADDR_W-1:0] ADDR_CNT = ADDR_W'(IDX_CNT * 4);
	localparam logic [ADDR_W-1:0] ADDR_RES = ADDR_W'(IDX_RES * 4);

	// Transaction control bits
	localparam int CTL_PRE = 7;
	localparam int CTL_SEQ = 6;
	localparam int CTL_SYNC = 5;
	localparam int CTL_ISO = 4;
	localparam int CTL_ARM = 0;

	// Byte count and port fields
	localparam int CNT_W = 10;
	localparam int CNT_PORT = 14;
	localparam int RXLEN_W = 11;

	// Result bits
	localparam int ST_OVF = 11;
	localparam int ST_UNF = 10;
	localparam int ST_STALL = 7;
	localparam int ST_NAK = 6;
	localparam int ST_LEN = 5;
	localparam int ST_SEQ = 3;
	localparam int ST_TMO = 2;
	localparam int ST_ERR = 1;
	localparam int ST_ACK = 0;

	// Token select fields
	localparam int TOK_CODE_LSB = 4;
	localparam int TOK_EP_LSB = 0;

	// Packet identifier codes
	localparam logic [3:0] CODE_SETUP = 4'hD;
	localparam logic [3:0] CODE_IN = 4'h9;
	localparam logic [3:0] CODE_OUT = 4'h1;
	localparam logic [3:0] CODE_SOF = 4'h5;
	localparam logic [3:0] CODE_PRE = 4'hC;
	localparam logic [3:0] CODE_ACK = 4'h2;
	localparam logic [3:0] CODE_NAK = 4'hA;
	localparam logic [3:0] CODE_STALL = 4'hE;
	localparam logic [3:0] CODE_DATA0 = 4'h3;
	localparam logic [3:0] CODE_DATA1 = 4'hB;

	// Answer timeout
	localparam int CLK_NS = 20;
	localparam int RESP_TIMEOUT_NS = 1500;
	localparam int TIMEOUT_CYC = RESP_TIMEOUT_NS / CLK_NS;

endpackage

// File: hdl/uht_timer.sv
// Purpose: Answer timeout counter
// Assumes: run stays high for the whole wait
// Notes: Clears whenever run drops
`timescale 1ns/10ps
module uht_timer #(
	parameter int LIMIT = uht_pkg::TIMEOUT_CYC,
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic run,
	output logic expired
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} uht_tmr_t;

	uht_tmr_t r;
	uht_tmr_t next_r;

	always_comb begin
		next_r = r;
		if (!run) begin
			next_r.cnt = '0;
		end else if (!expired) begin
			next_r.cnt = r.cnt + W'(1);
		end
	end

	assign expired = run && (r.cnt == W'(LIMIT - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule

// File: hdl/uht_len_check.sv
// Purpose: Compares received length with programmed byte count
// Assumes: Lengths in bytes
// Notes: Purely combinational
`timescale 1ns/10ps
module uht_len_check (
	// Lengths
	input wire logic [uht_pkg::CNT_W-1:0] count,
	input wire logic [uht_pkg::RXLEN_W-1:0] rx_len,
	// Results
	output logic over,
	output logic under
);
	logic [uht_pkg::RXLEN_W-1:0] cnt_ext;

	assign cnt_ext = {1'b0, count};
	assign over = rx_len > cnt_ext;
	assign under = rx_len < cnt_ext;
endmodule

// File: hdl/uht_host_xact.sv
// Purpose: Host transaction control for one serial interface engine
// Assumes: Packet layer sends packets and reports received ones
// Notes: APB slave, PREADY always high, read data from setup cycle
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module uht_host_xact #(
	parameter int TIMEOUT_CYC = uht_pkg::TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// APB slave
	input wire logic [uht_pkg::ADDR_W-1:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Packet send request
	output logic PKT_VALID,
	input wire logic PKT_READY,
	output logic [3:0] PKT_CODE,
	output logic [3:0] PKT_EP,
	output logic PKT_PORT_B,
	output logic [15:0] PKT_BUF,
	output logic [uht_pkg::CNT_W-1:0] PKT_LEN,
	// Received packet report
	input wire logic RX_VALID,
	input wire logic [3:0] RX_CODE,
	input wire logic [uht_pkg::RXLEN_W-1:0] RX_LEN,
	input wire logic RX_ERR,
	// Line state and busy flag
	input wire logic LOW_SPEED,
	input wire logic FRAME_MARK,
	output logic BUSY
);
	typedef enum logic [2:0] {S_IDLE, S_SYNC, S_SEND, S_WAIT} uht_state_t;
	typedef enum logic [1:0] {PH_TOKEN, PH_DATA, PH_HSK} uht_phase_t;

	typedef struct packed {
		logic pre;
		logic seq;
		logic sync;
		logic iso;
		logic arm;
		logic [15:0] bufp;
		logic port_b;
		logic [uht_pkg::CNT_W-1:0] cnt;
		logic [3:0] tok_code;
		logic [3:0] tok_ep;
		logic [15:0] status;
		logic [31:0] prdata;
		uht_state_t state;
		uht_phase_t phase;
		logic pre_pend;
		logic [3:0] code;
		logic rx_seq;
		logic ovf;
		logic unf;
	} uht_regs_t;

	uht_regs_t r;
	uht_regs_t next_r;
	logic fin;
	logic wr_en;
	logic mapped;
	logic tmo;
	logic over;
	logic under;
	logic is_in;

	function automatic logic [15:0] mk_status(input logic stall, input logic nak,
		input logic ovf, input logic unf, input logic seq, input logic to,
		input logic err, input logic ack);
		logic [15:0] s;
		s = '0;
		s[uht_pkg::ST_STALL] = stall;
		s[uht_pkg::ST_NAK] = nak;
		s[uht_pkg::ST_OVF] = ovf;
		s[uht_pkg::ST_UNF] = unf;
		s[uht_pkg::ST_LEN] = ovf | unf;
		s[uht_pkg::ST_SEQ] = seq & ~err;
		s[uht_pkg::ST_TMO] = to;
		s[uht_pkg::ST_ERR] = err;
		s[uht_pkg::ST_ACK] = ack;
		return s;
	endfunction

	uht_timer #(
		.LIMIT(TIMEOUT_CYC),
		.W(16)
	) u_timer (
		.clk(CLK),
		.rst(RST),
		.run(r.state == S_WAIT),
		.expired(tmo)
	);

	uht_len_check u_len (
		.count(r.cnt),
		.rx_len(RX_LEN),
		.over(over),
		.under(under)
	);

	assign mapped = (PADDR == uht_pkg::ADDR_CTRL) || (PADDR == uht_pkg::ADDR_BUFP) ||
		(PADDR == uht_pkg::ADDR_CNT) || (PADDR == uht_pkg::ADDR_RES);
	assign wr_en = PSEL && PENABLE && PWRITE && mapped;
	assign is_in = (r.tok_code == uht_pkg::CODE_IN);

	always_comb begin
		next_r = r;
		fin = 1'b0;
		// Read data captured in the setup cycle
		if (PSEL && !PENABLE) begin
			next_r.prdata = '0;
			unique case (PADDR)
				uht_pkg::ADDR_CTRL: begin
					next_r.prdata[uht_pkg::CTL_PRE] = r.pre;
					next_r.prdata[uht_pkg::CTL_SEQ] = r.seq;
					next_r.prdata[uht_pkg::CTL_SYNC] = r.sync;
					next_r.prdata[uht_pkg::CTL_ISO] = r.iso;
					next_r.prdata[uht_pkg::CTL_ARM] = r.arm;
				end
				uht_pkg::ADDR_BUFP: begin
					next_r.prdata[15:0] = r.bufp;
				end
				uht_pkg::ADDR_CNT: begin
					next_r.prdata[uht_pkg::CNT_PORT] = r.port_b;
					next_r.prdata[uht_pkg::CNT_W-1:0] = r.cnt;
				end
				uht_pkg::ADDR_RES: begin
					next_r.prdata[15:0] = r.status;
				end
				default: begin
					next_r.prdata = '0;
				end
			endcase
		end
		// Register writes
		if (wr_en) begin
			unique case (PADDR)
				uht_pkg::ADDR_CTRL: begin
					next_r.pre = PWDATA[uht_pkg::CTL_PRE];
					next_r.seq = PWDATA[uht_pkg::CTL_SEQ];
					next_r.sync = PWDATA[uht_pkg::CTL_SYNC];
					next_r.iso = PWDATA[uht_pkg::CTL_ISO];
					if (r.state == S_IDLE) begin
						next_r.arm = PWDATA[uht_pkg::CTL_ARM];
					end
				end
				uht_pkg::ADDR_BUFP: begin
					next_r.bufp = PWDATA[15:0];
				end
				// count and port, never cleared by mode
				uht_pkg::ADDR_CNT: begin
					next_r.port_b = PWDATA[uht_pkg::CNT_PORT];
					next_r.cnt = PWDATA[uht_pkg::CNT_W-1:0];
				end
				uht_pkg::ADDR_RES: begin
					next_r.tok_code = PWDATA[uht_pkg::TOK_CODE_LSB +: 4];
					next_r.tok_ep = PWDATA[uht_pkg::TOK_EP_LSB +: 4];
				end
				default: begin
					next_r.tok_ep = r.tok_ep;
				end
			endcase
		end
		// Transaction sequencer
		unique case (r.state)
			S_IDLE: begin
				if (r.arm) begin
					next_r.phase = PH_TOKEN;
					next_r.rx_seq = 1'b0;
					next_r.ovf = 1'b0;
					next_r.unf = 1'b0;
					if (r.sync) begin
						next_r.state = S_SYNC;
					end else begin
						next_r.state = S_SEND;
						next_r.pre_pend = r.pre && LOW_SPEED;
						next_r.code = (r.pre && LOW_SPEED) ? uht_pkg::CODE_PRE : r.tok_code;
					end
				end
			end
			S_SYNC: begin
				if (FRAME_MARK) begin
					next_r.state = S_SEND;
					next_r.pre_pend = r.pre && LOW_SPEED;
					next_r.code = (r.pre && LOW_SPEED) ? uht_pkg::CODE_PRE : r.tok_code;
				end
			end
			S_SEND: begin
				if (PKT_READY) begin
					if (r.pre_pend) begin
						next_r.pre_pend = 1'b0;
						unique case (r.phase)
							PH_TOKEN: next_r.code = r.tok_code;
							PH_DATA: next_r.code = r.seq ? uht_pkg::CODE_DATA1 :
								uht_pkg::CODE_DATA0;
							PH_HSK: next_r.code = uht_pkg::CODE_ACK;
						endcase
					end else begin
						unique case (r.phase)
							PH_TOKEN: begin
								if (is_in) begin
									next_r.state = S_WAIT;
								end else begin
									next_r.phase = PH_DATA;
									next_r.pre_pend = r.pre && LOW_SPEED;
									next_r.code = (r.pre && LOW_SPEED) ? uht_pkg::CODE_PRE :
										(r.seq ? uht_pkg::CODE_DATA1 : uht_pkg::CODE_DATA0);
								end
							end
							PH_DATA: begin
								if (r.iso) begin
									fin = 1'b1;
									next_r.status = mk_status(1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
										1'b0, 1'b0, 1'b1);
								end else begin
									next_r.state = S_WAIT;
								end
							end
							PH_HSK: begin
								fin = 1'b1;
								next_r.status = mk_status(1'b0, 1'b0, r.ovf, r.unf, r.rx_seq,
									1'b0, 1'b0, 1'b1);
							end
						endcase
					end
				end
			end
			S_WAIT: begin
				if (RX_VALID) begin
					if (RX_CODE == uht_pkg::CODE_STALL) begin
						fin = 1'b1;
						next_r.status = mk_status(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
					end else if (RX_CODE == uht_pkg::CODE_NAK) begin
						fin = 1'b1;
						next_r.status = mk_status(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
					end else if (!is_in && RX_CODE == uht_pkg::CODE_ACK && !RX_ERR) begin
						fin = 1'b1;
						next_r.status = mk_status(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
					end else if (is_in && !RX_ERR && (RX_CODE == uht_pkg::CODE_DATA0 ||
						RX_CODE == uht_pkg::CODE_DATA1)) begin
						if (r.iso) begin
							fin = 1'b1;
							next_r.status = mk_status(1'b0, 1'b0, over, under, RX_CODE[3],
								1'b0, 1'b0, 1'b1);
						end else begin
							next_r.rx_seq = RX_CODE[3];
							next_r.ovf = over;
							next_r.unf = under;
							next_r.phase = PH_HSK;
							next_r.state = S_SEND;
							next_r.pre_pend = r.pre && LOW_SPEED;
							next_r.code = (r.pre && LOW_SPEED) ? uht_pkg::CODE_PRE :
								uht_pkg::CODE_ACK;
						end
					end else begin
						fin = 1'b1;
						next_r.status = mk_status(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
					end
				end else if (tmo) begin
					fin = 1'b1;
					next_r.status = mk_status(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
				end
			end
		endcase
		if (fin) begin
			next_r.arm = 1'b0;
			next_r.state = S_IDLE;
			next_r.pre_pend = 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Outputs
	assign PRDATA = r.prdata;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PKT_VALID = (r.state == S_SEND);
	assign PKT_CODE = r.code;
	assign PKT_EP = r.tok_ep;
	assign PKT_PORT_B = r.port_b;
	assign PKT_BUF = r.bufp;
	assign PKT_LEN = r.cnt;
	assign BUSY = (r.state != S_IDLE);

	// Checks
	property p_pre_first;
		@(posedge CLK) disable iff (RST)
		(r.state == S_IDLE && r.arm && !r.sync && r.pre && LOW_SPEED) |=>
			PKT_VALID && PKT_CODE == uht_pkg::CODE_PRE;
	endproperty
	a_pre_first: assert property (p_pre_first) else $error("No preamble before packet");

	property p_toggle;
		@(posedge CLK) disable iff (RST)
		(PKT_VALID && r.phase == PH_DATA && !r.pre_pend) |->
			PKT_CODE == (r.seq ? uht_pkg::CODE_DATA1 : uht_pkg::CODE_DATA0);
	endproperty
	a_toggle: assert property (p_toggle) else $error("Wrong data toggle sent");

	property p_sync_hold;
		@(posedge CLK) disable iff (RST)
		(r.state == S_SYNC && !FRAME_MARK) |=> !PKT_VALID;
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("Sent before frame marker");

	property p_arm_clear;
		@(posedge CLK) disable iff (RST)
		fin |=> !r.arm && r.state == S_IDLE && !$stable(r.arm);
	endproperty
	a_arm_clear: assert property (p_arm_clear) else $error("Arm not cleared at end");

	property p_err_seq;
		@(posedge CLK) disable iff (RST)
		(r.state == S_WAIT && RX_VALID && RX_ERR && RX_CODE != uht_pkg::CODE_STALL &&
			RX_CODE != uht_pkg::CODE_NAK) |=>
			r.status[uht_pkg::ST_ERR] && !r.status[uht_pkg::ST_SEQ];
	endproperty
	a_err_seq: assert property (p_err_seq) else $error("Sequence set with error");

	property p_len_exc;
		@(posedge CLK) disable iff (RST)
		(r.state == S_WAIT && RX_VALID && is_in && !RX_ERR && RX_LEN != {1'b0, r.cnt} &&
			(RX_CODE == uht_pkg::CODE_DATA0 || RX_CODE == uht_pkg::CODE_DATA1)) |=>
			r.ovf || r.unf || r.status[uht_pkg::ST_LEN];
	endproperty
	a_len_exc: assert property (p_len_exc) else $error("Length exception mismatch");

	property p_timeout;
		@(posedge CLK) disable iff (RST)
		(r.state == S_WAIT && !RX_VALID) [*8] ##1 (r.state == S_WAIT) |->
			##[0:200] (r.state == S_IDLE);
	endproperty
	a_timeout: assert property (p_timeout) else $error("Wait never timed out");

	property p_stall;
		@(posedge CLK) disable iff (RST)
		(r.state == S_WAIT && RX_VALID && RX_CODE == uht_pkg::CODE_STALL) |=>
			r.status[uht_pkg::ST_STALL] && !r.status[uht_pkg::ST_ACK] && !r.arm;
	endproperty
	a_stall: assert property (p_stall) else $error("Stall not reported");

	property p_nak;
		@(posedge CLK) disable iff (RST)
		(r.state == S_WAIT && RX_VALID && RX_CODE == uht_pkg::CODE_NAK) |=>
			r.status[uht_pkg::ST_NAK] && !r.status[uht_pkg::ST_STALL];
	endproperty
	a_nak: assert property (p_nak) else $error("NAK not reported");

	c_ack_done: cover property (@(posedge CLK) disable iff (RST)
		fin ##1 r.status[uht_pkg::ST_ACK]);
	c_timeout: cover property (@(posedge CLK) disable iff (RST)
		fin ##1 r.status[uht_pkg::ST_TMO]);
	c_preamble: cover property (@(posedge CLK) disable iff (RST)
		PKT_VALID && PKT_READY && PKT_CODE == uht_pkg::CODE_PRE);
endmodule

// File: tb/uht_periph_model.sv
// Purpose: Behavioural USB peripheral behind the packet layer
// Assumes: Answers only after an IN token or a data packet
// Notes: Idle answer lines churn so stale values never pass
`timescale 1ns/10ps
module uht_periph_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Packet send side
	input wire logic pkt_valid,
	input wire logic [3:0] pkt_code,
	input wire logic [3:0] pkt_ep,
	input wire logic pkt_port_b,
	input wire logic [15:0] pkt_buf,
	input wire logic [9:0] pkt_len,
	output logic pkt_ready,
	// Answer side
	output logic rx_valid,
	output logic [3:0] rx_code,
	output logic [10:0] rx_len,
	output logic rx_err,
	// Behaviour control
	input wire logic resp_en,
	input wire logic [3:0] resp_code,
	input wire logic [10:0] resp_len,
	input wire logic resp_err,
	input wire logic slow
);
	logic [3:0] sent[$];
	logic [3:0] ep;
	logic port_b;
	logic [15:0] bptr;
	logic [9:0] len;
	int wait_cnt;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pkt_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_code <= 4'h0;
			rx_len <= 11'h000;
			rx_err <= 1'b0;
			wait_cnt <= 0;
		end else begin
			pkt_ready <= slow ? ~pkt_ready : 1'b1;
			rx_valid <= 1'b0;
			rx_code <= ~rx_code;
			rx_len <= ~rx_len;
			rx_err <= ~rx_err;
			if (wait_cnt == 1) begin
				rx_valid <= 1'b1;
				rx_code <= resp_code;
				rx_len <= resp_len;
				rx_err <= resp_err;
			end
			if (wait_cnt > 0)
				wait_cnt <= wait_cnt - 1;
			if (pkt_valid && pkt_ready) begin
				sent.push_back(pkt_code);
				ep <= pkt_ep;
				port_b <= pkt_port_b;
				bptr <= pkt_buf;
				len <= pkt_len;
				if (resp_en && pkt_code inside {4'h9, 4'h3, 4'hB})
					wait_cnt <= 3;
			end
		end
	end
endmodule

// File: tb/usb_host_transaction_control_tb.sv
// Purpose: Self-checking bench for the host transaction block
// Assumes: Zero-wait APB slave, peripheral model on packet side
// Notes: Expected results come from a behavioural model of the rules
`timescale 1ns/10ps
module usb_host_transaction_control_tb;
	localparam logic [3:0] K_IN = uht_pkg::CODE_IN;
	localparam logic [3:0] K_OUT = uht_pkg::CODE_OUT;
	localparam logic [3:0] K_SET = uht_pkg::CODE_SETUP;
	localparam logic [3:0] K_D0 = uht_pkg::CODE_DATA0;
	localparam logic [3:0] K_D1 = uht_pkg::CODE_DATA1;
	localparam logic [3:0] K_ACK = uht_pkg::CODE_ACK;
	localparam logic [3:0] K_NAK = uht_pkg::CODE_NAK;
	localparam logic [3:0] K_STL = uht_pkg::CODE_STALL;
	localparam logic [3:0] K_PRE = uht_pkg::CODE_PRE;
	logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PKT_VALID, PKT_READY, PKT_PORT_B;
	logic [uht_pkg::ADDR_W-1:0] PADDR;
	logic [31:0] PWDATA, PRDATA, seed;
	logic [3:0] PKT_CODE, PKT_EP, RX_CODE, m_rc;
	logic [15:0] PKT_BUF;
	logic [9:0] PKT_LEN;
	logic [10:0] RX_LEN, m_len;
	logic RX_VALID, RX_ERR, LOW_SPEED, FRAME_MARK, BUSY, m_ren, m_err, m_slow;
	int failures, cmp_count, tcount;
	uht_host_xact #(.TIMEOUT_CYC(10)) DUT (.CLK(CLK), .RST(RST), .PADDR(PADDR), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .PKT_VALID(PKT_VALID), .PKT_READY(PKT_READY), .PKT_CODE(PKT_CODE),
		.PKT_EP(PKT_EP), .PKT_PORT_B(PKT_PORT_B), .PKT_BUF(PKT_BUF), .PKT_LEN(PKT_LEN),
		.RX_VALID(RX_VALID), .RX_CODE(RX_CODE), .RX_LEN(RX_LEN), .RX_ERR(RX_ERR),
		.LOW_SPEED(LOW_SPEED), .FRAME_MARK(FRAME_MARK), .BUSY(BUSY));
	uht_periph_model u_dev (.clk(CLK), .rst(RST), .pkt_valid(PKT_VALID), .pkt_code(PKT_CODE),
		.pkt_ep(PKT_EP), .pkt_port_b(PKT_PORT_B), .pkt_buf(PKT_BUF), .pkt_len(PKT_LEN),
		.pkt_ready(PKT_READY), .rx_valid(RX_VALID), .rx_code(RX_CODE), .rx_len(RX_LEN),
		.rx_err(RX_ERR), .resp_en(m_ren), .resp_code(m_rc), .resp_len(m_len),
		.resp_err(m_err), .slow(m_slow));
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic give_verdict();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input bit wr, input logic [uht_pkg::ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
		end
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic run(input logic [3:0] tok, input bit iso, sq, pre, ls, syn, ren,
		input logic [3:0] rc, input int dl, input bit re, sl);
		logic [3:0] exq[$];
		logic [31:0] r, st, bp, ct;
		logic [3:0] ep;
		logic e, prt, inp, dat;
		int n;
		bp = xs();
		ct = 2 + xs() % 1000;
		ep = 4'(xs());
		prt = 1'(xs());
		inp = tok == K_IN;
		dat = rc == K_D0 || rc == K_D1;
		u_dev.sent.delete();
		m_ren <= ren;
		m_rc <= rc;
		m_len <= 11'(ct + dl);
		m_err <= re;
		m_slow <= sl;
		LOW_SPEED <= ls;
		apb(1, uht_pkg::ADDR_BUFP, {16'h0000, bp[15:0]}, r, e);
		apb(1, uht_pkg::ADDR_CNT, {17'h0_0000, prt, 4'h0, ct[9:0]}, r, e);
		apb(1, uht_pkg::ADDR_RES, {24'h00_0000, tok, ep}, r, e);
		apb(1, uht_pkg::ADDR_CTRL, {24'h00_0000, pre, sq, syn, iso, 4'h1}, r, e);
		if (syn) begin
			repeat (6) @(posedge CLK);
			check("send before frame mark", PKT_VALID, 0);
			FRAME_MARK <= 1'b1;
			@(posedge CLK);
			FRAME_MARK <= 1'b0;
		end
		n = 0;
		repeat (2) @(posedge CLK);
		while (BUSY !== 1'b0 && n < 300) begin
			@(posedge CLK);
			n++;
		end
		if (n >= 300) begin
			failures++;
		end
		if (pre && ls) exq.push_back(K_PRE);
		exq.push_back(tok);
		if (!inp) begin
			if (pre && ls) exq.push_back(K_PRE);
			exq.push_back(sq ? K_D1 : K_D0);
		end else if (!iso && ren && dat && !re) begin
			if (pre && ls) exq.push_back(K_PRE);
			exq.push_back(K_ACK);
		end
		st = 0;
		if (iso && !inp) st[uht_pkg::ST_ACK] = 1;
		else if (!ren) st[uht_pkg::ST_TMO] = 1;
		else if (re) st[uht_pkg::ST_ERR] = 1;
		else if (rc == K_NAK) st[uht_pkg::ST_NAK] = 1;
		else if (rc == K_STL) st[uht_pkg::ST_STALL] = 1;
		else if (inp && dat) begin
			st[uht_pkg::ST_ACK] = 1;
			st[uht_pkg::ST_SEQ] = rc == K_D1;
			st[uht_pkg::ST_OVF] = dl > 0;
			st[uht_pkg::ST_UNF] = dl < 0;
			st[uht_pkg::ST_LEN] = dl != 0;
		end else if (!inp && rc == K_ACK) st[uht_pkg::ST_ACK] = 1;
		else st[uht_pkg::ST_ERR] = 1;
		apb(0, uht_pkg::ADDR_RES, 0, r, e);
		check("result", r, st);
		apb(0, uht_pkg::ADDR_CTRL, 0, r, e);
		check("control", r, {24'h00_0000, pre, sq, syn, iso, 4'h0});
		check("packet count", u_dev.sent.size(), exq.size());
		for (int i = 0; i < exq.size() && i < u_dev.sent.size(); i++)
			check("packet code", u_dev.sent[i], exq[i]);
		check("endpoint", u_dev.ep, ep);
		check("port", u_dev.port_b, prt);
		check("buffer", u_dev.bptr, bp[15:0]);
		check("length", u_dev.len, ct[9:0]);
		tcount++;
		$display("test %0d done", tcount);
	endtask
	logic [uht_pkg::ADDR_W-1:0] ra[4];
	logic [31:0] rexp[4];
	logic [31:0] rd;
	logic er;
	initial begin
		seed = 32'h0000_0059;
		{failures, cmp_count, tcount} = 0;
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 0;
		{FRAME_MARK, LOW_SPEED, m_ren, m_rc, m_len, m_err, m_slow} = 0;
		RST = 1'b1;
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		ra = '{uht_pkg::ADDR_CTRL, uht_pkg::ADDR_BUFP, uht_pkg::ADDR_CNT, uht_pkg::ADDR_RES};
		rexp = '{32'h0000_00F0, 32'h0000_FFFE, 32'h0000_43FE, 32'h0000_0000};
		for (int i = 0; i < 4; i++) begin
			apb(0, ra[i], 0, rd, er);
			check("reset value", rd, 0);
			apb(1, ra[i], 32'hFFFF_FFFE, rd, er);
			apb(0, ra[i], 0, rd, er);
			check("read back", rd, rexp[i]);
		end
		apb(1, uht_pkg::ADDR_CTRL + 4, 32'hFFFF_FFFF, rd, er);
		check("unmapped error", er, 1);
		apb(0, uht_pkg::ADDR_CTRL + 4, 0, rd, er);
		check("unmapped data", rd, 0);
		$display("test registers done");
		run(K_OUT, 0, 0, 0, 0, 0, 1, K_ACK, 0, 0, 0);
		run(K_SET, 0, 1, 1, 1, 0, 1, K_ACK, 0, 0, 1);
		run(K_OUT, 0, 1, 1, 0, 0, 1, K_NAK, 0, 0, 0);
		run(K_OUT, 0, 0, 0, 0, 1, 1, K_STL, 0, 0, 1);
		run(K_OUT, 0, 0, 0, 0, 0, 0, K_ACK, 0, 0, 0);
		run(K_IN, 0, 0, 1, 1, 0, 1, K_D1, 0, 0, 1);
		run(K_IN, 0, 1, 0, 0, 0, 1, K_D0, 1, 0, 0);
		run(K_IN, 0, 0, 0, 0, 1, 1, K_D1, -1, 0, 0);
		run(K_IN, 0, 0, 0, 0, 0, 1, K_D1, 0, 1, 0);
		run(K_IN, 0, 0, 0, 0, 0, 1, K_NAK, 0, 0, 1);
		run(K_OUT, 0, 0, 0, 0, 0, 1, K_D0, 0, 0, 0);
		run(K_IN, 1, 0, 0, 0, 0, 1, K_D0, 0, 0, 0);
		run(K_OUT, 1, 1, 1, 1, 0, 0, K_ACK, 0, 0, 1);
		run(K_IN, 0, 1, 0, 0, 0, 0, K_ACK, 0, 0, 0);
		// Reset in the middle of a transaction
		apb(1, uht_pkg::ADDR_CTRL, 32'h0000_0001, rd, er);
		repeat (3) @(posedge CLK);
		check("busy before reset", BUSY, 1);
		RST <= 1'b1;
		@(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		check("busy after reset", BUSY, 0);
		check("send after reset", PKT_VALID, 0);
		apb(0, uht_pkg::ADDR_CTRL, 0, rd, er);
		check("control after reset", rd, 0);
		$display("test mid reset done");
		give_verdict();
	end
endmodule
